// ### hw/spm_pkg.sv
package spm_pkg;

   // Sizes
   localparam int NPART = 16;
   localparam int NPORT = 16;
   localparam int AXI_AW = 8;

   // Partition state codes; code 2'h3 is reserved and writes of it are ignored
   localparam logic [1:0] ST_DIS = 2'h0;
   localparam logic [1:0] ST_FR = 2'h1;
   localparam logic [1:0] ST_ACT = 2'h2;
   localparam logic [1:0] ST_RSVD = 2'h3;
   localparam logic [1:0] ST_RST_VAL = ST_ACT;

   // Port mode codes
   localparam logic [1:0] PM_DIS = 2'h0;
   localparam logic [1:0] PM_UNATT = 2'h1;
   localparam logic [1:0] PM_US = 2'h2;
   localparam logic [1:0] PM_DS = 2'h3;
   localparam logic [1:0] PM_RST_VAL = PM_UNATT;

   // Address map: region in addr[7:6], index in addr[5:2]
   localparam logic [1:0] RG_PCTL = 2'h0;
   localparam logic [1:0] RG_PSTS = 2'h1;
   localparam logic [1:0] RG_PORT = 2'h2;
   localparam logic [1:0] RG_MISC = 2'h3;
   localparam logic [3:0] MX_RDRAIN = 4'h0;
   localparam logic [3:0] MX_SEDLY = 4'h1;
   localparam logic [3:0] MX_MCDLY = 4'h2;
   localparam logic [3:0] MX_USBR = 4'h3;
   localparam logic [3:0] MX_PINEN = 4'h4;

   // Field positions
   localparam int CT_STATE_LSB = 0;
   localparam int CT_DLHR_BIT = 2;
   localparam int SS_US_BIT = 0;
   localparam int SS_USN_LSB = 4;
   localparam int SS_CI_BIT = 8;
   localparam int SS_CC_BIT = 9;
   localparam int PC_MODE_LSB = 0;
   localparam int PC_SEL_LSB = 4;

   // Timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int RD_TIME_US = 250;
   localparam int RD_CYC_DEF = (RD_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [15:0] SE_CYC_DEF = 16'h0004;
   localparam logic [15:0] MC_CYC_DEF = 16'h0010;
   localparam logic [15:0] USBR_DEF = 16'h0010;

   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ### hw/spm_part.sv
`timescale 1ns/1ps
`default_nettype none
module spm_part (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // State change requests
   input wire logic wr_state,
   input wire logic [1:0] new_state,
   input wire logic clr_ci,
   input wire logic clr_cc,
   input wire logic pin_rst,
   input wire logic has_ports,
   // Timer values in cycles
   input wire logic [15:0] se_delay,
   input wire logic [15:0] rd_delay,
   input wire logic [15:0] mc_delay,
   // State and status
   output logic [1:0] state_q,
   output logic ci_q,
   output logic cc_q,
   output logic part_rst
);
   import spm_pkg::*;

   typedef enum logic [3:0] {
      PH_IDLE = 4'h1,
      PH_DRAIN = 4'h2,
      PH_MODE = 4'h4,
      PH_PIN = 4'h8
   } spm_phase_t;

   spm_phase_t phase_q;
   logic [15:0] cnt_q;
   logic [1:0] from_q;
   logic mode_alt_q;
   logic accept;
   logic pin_hold;
   logic done;

   assign accept = wr_state && (new_state != ST_RSVD);
   assign pin_hold = pin_rst && (state_q == ST_ACT) && (from_q != ST_ACT);
   assign done = (phase_q == PH_PIN) && !pin_hold;
   assign part_rst = (state_q == ST_FR) || pin_rst;

   ////////////////////////////////////////////////////////////////////////////
   // State register and sequencing
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_q <= ST_RST_VAL;
         from_q <= ST_RST_VAL;
         mode_alt_q <= 1'b0;
         cnt_q <= 16'h0000;
         phase_q <= PH_IDLE;
      end else if (accept) begin
         state_q <= new_state;
         from_q <= state_q;
         // Port modes change on entering or leaving disabled
         mode_alt_q <= has_ports && ((new_state == ST_DIS) != (state_q == ST_DIS));
         // Reset entry waits the drain time
         cnt_q <= (new_state == ST_FR) ? rd_delay : se_delay;
         phase_q <= PH_DRAIN;
      end else begin
         case (phase_q)
            PH_DRAIN: begin
               if (cnt_q == 16'h0000) begin
                  cnt_q <= mc_delay;
                  phase_q <= mode_alt_q ? PH_MODE : PH_PIN;
               end else begin
                  cnt_q <= 16'(cnt_q - 16'h0001);
               end
            end
            PH_MODE: begin
               if (cnt_q == 16'h0000) begin
                  phase_q <= PH_PIN;
               end else begin
                  cnt_q <= 16'(cnt_q - 16'h0001);
               end
            end
            PH_PIN: begin
               if (!pin_hold) begin
                  phase_q <= PH_IDLE;
               end
            end
            default: phase_q <= PH_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Initiated and completed flags
   // Sticky; a write clears completed first
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         ci_q <= 1'b0;
         cc_q <= 1'b0;
      end else begin
         if (accept) begin
            ci_q <= 1'b1;
         end else if (clr_ci) begin
            ci_q <= 1'b0;
         end
         // Completion beats a software clear in the same cycle
         if (accept) begin
            cc_q <= 1'b0;
         end else if (done) begin
            cc_q <= 1'b1;
         end else if (clr_cc) begin
            cc_q <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);

   a_write_flags: assert property (accept |=> ci_q && !cc_q)
      else $error("state write did not set initiated and clear completed");
   a_cc_after_wait: assert property ($rose(cc_q) |-> $past(phase_q) == PH_PIN)
      else $error("completed set without finishing the wait");
   a_pin_blocks_cc: assert property (pin_hold && !accept |=> !$rose(cc_q))
      else $error("completed set while reset pin held");
   a_fr_drain_min: assert property (accept && new_state == ST_FR && rd_delay > 16'h0002
      |=> !cc_q [*3])
      else $error("reset entry completed too early");
   a_reset_level: assert property (state_q == ST_FR |-> part_rst)
      else $error("partition reset dropped while in reset state");
   c_fr_done: cover property (from_q == ST_ACT && state_q == ST_FR && $rose(cc_q));
   c_pin_wait: cover property (phase_q == PH_PIN && pin_hold ##1 !pin_hold ##1 $rose(cc_q));

endmodule
`default_nettype wire

// ### hw/spm_top.sv
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module spm_top #(
   parameter logic [15:0] RESET_DRAIN_CYC = 16'(spm_pkg::RD_CYC_DEF)
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // AXI4-Lite write
   input wire logic [spm_pkg::AXI_AW-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [spm_pkg::AXI_AW-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Partition reset pins
   input wire logic [spm_pkg::NPART-1:0] partition_reset_pin_n,
   // TLP classification
   input wire logic tlp_valid,
   input wire logic [3:0] tlp_port,
   input wire logic tlp_is_cpl,
   input wire logic tlp_cfg_to_us,
   input wire logic tlp_to_ds,
   input wire logic tlp_to_root,
   output logic tlp_done,
   output logic tlp_fwd,
   output logic tlp_ur,
   output logic tlp_drop,
   // Port control
   output logic [spm_pkg::NPORT-1:0][1:0] port_mode_eff,
   output logic [spm_pkg::NPORT-1:0] port_fund_rst,
   output logic [spm_pkg::NPORT-1:0] port_aspm_free
);
   import spm_pkg::*;

   logic aw_have_q;
   logic w_have_q;
   logic [AXI_AW-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic do_wr;
   logic [1:0] wr_rg;
   logic [3:0] wr_ix;
   logic wr_hit;
   logic [31:0] rd_word;
   logic rd_hit;
   logic [NPORT-1:0][1:0] pmode_q;
   logic [NPORT-1:0][3:0] psel_q;
   logic [NPART-1:0] dlhr_q;
   logic [15:0] rdrain_q, sedly_q, mcdly_q, usbr_q;
   logic [NPART-1:0] pin_en_q;
   logic [NPART-1:0][1:0] pstate;
   logic [NPART-1:0] ci, cc, prst, pin_rst;
   logic [NPART-1:0] has_us, has_ds;
   logic [NPART-1:0][3:0] us_num;
   logic [NPART-1:0] wr_ctl, clr_ci, clr_cc;
   logic [3:0] tp;
   logic t_att;
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
      return (old & ~m) | (nw & m);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Write channel: address and data taken in either order
   assign s_axi_awready = !aw_have_q;
   assign s_axi_wready = !w_have_q;
   assign do_wr = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wr_rg = awaddr_q[7:6];
   assign wr_ix = awaddr_q[5:2];
   assign wr_hit = (wr_rg != RG_MISC) || (wr_ix <= MX_PINEN);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= 32'h00000000;
         wstrb_q <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end else if (do_wr) begin
            aw_have_q <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end else if (do_wr) begin
            w_have_q <= 1'b0;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write strobes into the partition engines
   always_comb begin
      wr_ctl = '0;
      clr_ci = '0;
      clr_cc = '0;
      if (do_wr && wr_rg == RG_PCTL) begin
         wr_ctl[wr_ix] = wstrb_q[0];
      end else if (do_wr && wr_rg == RG_PSTS && wstrb_q[1]) begin
         clr_ci[wr_ix] = wdata_q[SS_CI_BIT];
         clr_cc[wr_ix] = wdata_q[SS_CC_BIT];
      end
   end
   // Configuration registers
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pmode_q <= {NPORT{PM_RST_VAL}};
         psel_q <= '0;
         dlhr_q <= '0;
         rdrain_q <= 16'h0000;
         sedly_q <= SE_CYC_DEF;
         mcdly_q <= MC_CYC_DEF;
         usbr_q <= USBR_DEF;
         pin_en_q <= '0;
      end else if (do_wr) begin
         if (wr_rg == RG_PCTL && wstrb_q[0]) begin
            dlhr_q[wr_ix] <= wdata_q[CT_DLHR_BIT];
         end else if (wr_rg == RG_PORT && wstrb_q[0]) begin
            pmode_q[wr_ix] <= wdata_q[PC_MODE_LSB +: 2];
            psel_q[wr_ix] <= wdata_q[PC_SEL_LSB +: 4];
         end else if (wr_rg == RG_MISC && wr_ix == MX_RDRAIN) begin
            rdrain_q <= 16'(merge({16'h0000, rdrain_q}, wdata_q, wstrb_q));
         end else if (wr_rg == RG_MISC && wr_ix == MX_SEDLY) begin
            sedly_q <= 16'(merge({16'h0000, sedly_q}, wdata_q, wstrb_q));
         end else if (wr_rg == RG_MISC && wr_ix == MX_MCDLY) begin
            mcdly_q <= 16'(merge({16'h0000, mcdly_q}, wdata_q, wstrb_q));
         end else if (wr_rg == RG_MISC && wr_ix == MX_USBR) begin
            usbr_q <= 16'(merge({16'h0000, usbr_q}, wdata_q, wstrb_q));
         end else if (wr_rg == RG_MISC && wr_ix == MX_PINEN) begin
            pin_en_q <= 16'(merge({16'h0000, pin_en_q}, wdata_q, wstrb_q));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read channel, answered one cycle after the address is taken
   assign s_axi_arready = !s_axi_rvalid;
   always_comb begin
      rd_word = 32'h00000000;
      rd_hit = 1'b1;
      if (s_axi_araddr[7:6] == RG_PCTL) begin
         rd_word[CT_STATE_LSB +: 2] = pstate[s_axi_araddr[5:2]];
         rd_word[CT_DLHR_BIT] = dlhr_q[s_axi_araddr[5:2]];
      end else if (s_axi_araddr[7:6] == RG_PSTS) begin
         rd_word[SS_US_BIT] = has_us[s_axi_araddr[5:2]];
         rd_word[SS_USN_LSB +: 4] = has_us[s_axi_araddr[5:2]] ? us_num[s_axi_araddr[5:2]] : 4'h0;
         rd_word[SS_CI_BIT] = ci[s_axi_araddr[5:2]];
         rd_word[SS_CC_BIT] = cc[s_axi_araddr[5:2]];
      end else if (s_axi_araddr[7:6] == RG_PORT) begin
         rd_word[PC_MODE_LSB +: 2] = pmode_q[s_axi_araddr[5:2]];
         rd_word[PC_SEL_LSB +: 4] = psel_q[s_axi_araddr[5:2]];
      end else if (s_axi_araddr[5:2] == MX_RDRAIN) begin
         rd_word[15:0] = rdrain_q;
      end else if (s_axi_araddr[5:2] == MX_SEDLY) begin
         rd_word[15:0] = sedly_q;
      end else if (s_axi_araddr[5:2] == MX_MCDLY) begin
         rd_word[15:0] = mcdly_q;
      end else if (s_axi_araddr[5:2] == MX_USBR) begin
         rd_word[15:0] = usbr_q;
      end else if (s_axi_araddr[5:2] == MX_PINEN) begin
         rd_word[15:0] = pin_en_q;
      end else begin
         rd_hit = 1'b0;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_word;
         s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port attachment per partition
   // Lowest numbered upstream port wins if software sets up two
   always_comb begin
      has_us = '0;
      has_ds = '0;
      us_num = '0;
      for (int i = NPORT - 1; i >= 0; i--) begin
         if (pmode_q[i] == PM_US) begin
            has_us[psel_q[i]] = 1'b1;
            us_num[psel_q[i]] = 4'(i);
         end
         if (pmode_q[i] == PM_DS) begin
            has_ds[psel_q[i]] = 1'b1;
         end
      end
   end

   for (genvar p = 0; p < NPART; p++) begin : g_part
      assign pin_rst[p] = pin_en_q[p] && !partition_reset_pin_n[p];
      spm_part u_part (
         .clk_sys(clk_sys),
         .arst_n(arst_n),
         .wr_state(wr_ctl[p]),
         .new_state(wdata_q[CT_STATE_LSB +: 2]),
         .clr_ci(clr_ci[p]),
         .clr_cc(clr_cc[p]),
         .pin_rst(pin_rst[p]),
         .has_ports(has_us[p] || has_ds[p]),
         .se_delay(sedly_q),
         .rd_delay((rdrain_q == 16'h0000) ? RESET_DRAIN_CYC : rdrain_q),
         .mc_delay(mcdly_q),
         .state_q(pstate[p]),
         .ci_q(ci[p]),
         .cc_q(cc[p]),
         .part_rst(prst[p])
      );
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-port effective mode, reset and power freedom
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         port_mode_eff <= {NPORT{PM_RST_VAL}};
         port_fund_rst <= '0;
         port_aspm_free <= '0;
      end else begin
         for (int i = 0; i < NPORT; i++) begin
            if ((pmode_q[i] == PM_US || pmode_q[i] == PM_DS) && pstate[psel_q[i]] == ST_DIS) begin
               port_mode_eff[i] <= PM_DIS;
            end else begin
               port_mode_eff[i] <= pmode_q[i];
            end
            port_fund_rst[i] <= (pmode_q[i] == PM_US || pmode_q[i] == PM_DS) && prst[psel_q[i]];
            port_aspm_free[i] <= (pmode_q[i] == PM_US && !has_ds[psel_q[i]]) ||
                                 (pmode_q[i] == PM_DS && !has_us[psel_q[i]]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // TLP handling; unattached ports give no forward or UR and the TLP is dropped
   assign tp = psel_q[tlp_port];
   assign t_att = (pmode_q[tlp_port] == PM_US) || (pmode_q[tlp_port] == PM_DS);

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         tlp_done <= 1'b0;
         tlp_fwd <= 1'b0;
         tlp_ur <= 1'b0;
         tlp_drop <= 1'b0;
      end else begin
         tlp_done <= tlp_valid;
         tlp_fwd <= 1'b0;
         tlp_ur <= 1'b0;
         tlp_drop <= 1'b0;
         if (tlp_valid && !t_att) begin
            tlp_drop <= 1'b1;
         end else if (tlp_valid && has_us[tp] && !has_ds[tp]) begin
            // Only config to the upstream port passes
            tlp_ur <= tlp_is_cpl || !tlp_cfg_to_us;
            tlp_fwd <= !tlp_is_cpl && tlp_cfg_to_us;
         end else if (tlp_valid && !has_us[tp]) begin
            tlp_drop <= tlp_to_root;
            tlp_fwd <= !tlp_to_root && tlp_to_ds;
            tlp_ur <= !tlp_to_root && !tlp_to_ds;
         end else if (tlp_valid) begin
            tlp_fwd <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_us_only_ur: assert property (tlp_valid && t_att && has_us[tp] && !has_ds[tp] &&
      tlp_is_cpl |=> tlp_ur && !tlp_fwd)
      else $error("completion in upstream-only partition not UR");
   a_p2p_forward: assert property (tlp_valid && t_att && !has_us[tp] && tlp_to_ds &&
      !tlp_to_root |=> tlp_fwd && !tlp_ur)
      else $error("peer TLP not forwarded");
   a_root_drop: assert property (tlp_valid && t_att && !has_us[tp] && tlp_to_root
      |=> tlp_drop && !tlp_fwd)
      else $error("rootward TLP not dropped");
   a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   for (genvar g = 0; g < NPORT; g++) begin : g_chk
      a_dis_force: assert property (pmode_q[g] == PM_DS && pstate[psel_q[g]] == ST_DIS
         |=> port_mode_eff[g] == PM_DIS)
         else $error("port of disabled partition not forced");
      a_aspm_us: assert property (pmode_q[g] == PM_US && !has_ds[psel_q[g]]
         |=> port_aspm_free[g])
         else $error("lone upstream port not power independent");
      a_aspm_ds: assert property (pmode_q[g] == PM_DS && !has_us[psel_q[g]]
         |=> port_aspm_free[g])
         else $error("downstream port tied to absent upstream");
      a_port_reset: assert property (pmode_q[g] == PM_US && pstate[psel_q[g]] == ST_FR
         |=> port_fund_rst[g])
         else $error("attached port not held in reset");
   end
   c_ur_seen: cover property (tlp_done && tlp_ur);
   c_wr_resp: cover property (s_axi_bvalid && s_axi_bready);

endmodule
`default_nettype wire

// ### testbench/spm_cfg_master.sv
`timescale 1ns/1ps
`default_nettype none
// Register master in place of the configuration agent
module spm_cfg_master (
   // Clock
   input wire logic clk_sys,
   // Write channels
   output logic [7:0] awaddr,
   output logic awvalid,
   input wire logic awready,
   output logic [31:0] wdata,
   output logic wvalid,
   input wire logic wready,
   input wire logic [1:0] bresp,
   input wire logic bvalid,
   output logic bready,
   // Read channels
   output logic [7:0] araddr,
   output logic arvalid,
   input wire logic arready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   input wire logic rvalid,
   output logic rready
);
   initial begin
      {awaddr, awvalid, wdata, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
   end
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic a_p, w_p, b_p;
      {a_p, w_p, b_p} = 3'h7;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      r = 2'h1;
      // Local flags: the driven signals still show old values in this step
      while (a_p || w_p || b_p) begin
         @(posedge clk_sys);
         if (a_p && awready) begin
            awvalid <= 1'b0;
            a_p = 1'b0;
         end
         if (w_p && wready) begin
            wvalid <= 1'b0;
            w_p = 1'b0;
         end
         if (b_p && bvalid) begin
            r = bresp;
            bready <= 1'b0;
            b_p = 1'b0;
         end
      end
      // Idle edge so a following call never re-raises bready in this step
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      logic a_p, r_p;
      {a_p, r_p} = 2'h3;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      {d, r} = '1;
      while (a_p || r_p) begin
         @(posedge clk_sys);
         if (a_p && arready) begin
            arvalid <= 1'b0;
            a_p = 1'b0;
         end
         if (r_p && rvalid) begin
            {d, r} = {rdata, rresp};
            rready <= 1'b0;
            r_p = 1'b0;
         end
      end
      @(posedge clk_sys);
   endtask
   task automatic wait_cc(input logic [3:0] p, output logic [31:0] d);
      logic [1:0] r;
      int n;
      d = '0;
      n = 0;
      while (d[9] !== 1'b1 && n < 300) begin
         rd(8'h40 + {2'h0, p, 2'h0}, d, r);
         n++;
      end
   endtask
endmodule
`default_nettype wire

// ### testbench/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import spm_pkg::*;
   logic clk_sys = 1'b0;
   logic arst_n = 1'b0;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp;
   logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
   logic [15:0] pin_n = 16'hFFFF;
   logic tlp_valid = 1'b0;
   logic [3:0] tlp_port = 4'h0;
   logic tlp_is_cpl = 1'b0, tlp_cfg_to_us = 1'b0, tlp_to_ds = 1'b0, tlp_to_root = 1'b0;
   logic tlp_done, tlp_fwd, tlp_ur, tlp_drop;
   logic [NPORT-1:0][1:0] port_mode_eff;
   logic [NPORT-1:0] port_fund_rst, port_aspm_free;
   int num_errors = 0;
   int check_count = 0;
   // Rows: write flag, address, response, data or expected data
   logic [42:0] rw [7] = '{{1'b0, 8'h04, 2'h0, 32'h2}, {1'b1, 8'h8C, 2'h0, 32'h12},
      {1'b1, 8'h94, 2'h0, 32'h23}, {1'b0, 8'h44, 2'h0, 32'h31}, {1'b0, 8'h48, 2'h0, 32'h0},
      {1'b0, 8'h94, 2'h0, 32'h23}, {1'b0, 8'hFC, 2'h2, 32'h0}};
   // Rows: port, cpl, cfg_to_us, to_ds, to_root, expected fwd ur drop
   logic [10:0] tl [7] = '{{4'h3, 4'h0, 3'h2}, {4'h3, 4'h4, 3'h4}, {4'h3, 4'hC, 3'h2},
      {4'h5, 4'h1, 3'h1}, {4'h5, 4'h2, 3'h4}, {4'h5, 4'h0, 3'h2}, {4'h0, 4'h2, 3'h1}};
   always #12.5 clk_sys = ~clk_sys;
   spm_cfg_master u_spm_cfg_master (.clk_sys(clk_sys), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp),
      .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
      .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
   // Short drain count keeps the run brief
   spm_top #(.RESET_DRAIN_CYC(16'h0014)) u_spm_top (.clk_sys(clk_sys), .arst_n(arst_n),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .partition_reset_pin_n(pin_n), .tlp_valid(tlp_valid), .tlp_port(tlp_port),
      .tlp_is_cpl(tlp_is_cpl), .tlp_cfg_to_us(tlp_cfg_to_us), .tlp_to_ds(tlp_to_ds),
      .tlp_to_root(tlp_to_root), .tlp_done(tlp_done), .tlp_fwd(tlp_fwd), .tlp_ur(tlp_ur),
      .tlp_drop(tlp_drop), .port_mode_eff(port_mode_eff), .port_fund_rst(port_fund_rst),
      .port_aspm_free(port_aspm_free));
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clk_sys);
      num_errors++;
      report_and_stop();
   end
   ////////////////////////////////////////////////////////////////////////
   initial begin
      logic [31:0] d;
      logic [1:0] r;
      time t0;
      repeat (10) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      foreach (rw[i]) begin
         if (rw[i][42]) u_spm_cfg_master.wr(rw[i][41:34], rw[i][31:0], r);
         else u_spm_cfg_master.rd(rw[i][41:34], d, r);
         if (!rw[i][42]) chk(d, rw[i][31:0]);
         chk(32'(r), 32'(rw[i][33:32]));
      end
      $display("register table done");
      foreach (tl[i]) begin
         @(posedge clk_sys);
         {tlp_port, tlp_is_cpl, tlp_cfg_to_us, tlp_to_ds, tlp_to_root} <= tl[i][10:3];
         tlp_valid <= 1'b1;
         @(posedge clk_sys);
         tlp_valid <= 1'b0;
         #1 chk(32'({tlp_done, tlp_fwd, tlp_ur, tlp_drop}), {28'h0, 1'b1, tl[i][2:0]});
      end
      chk(32'({port_aspm_free[5], port_aspm_free[3]}), 32'h3);
      $display("traffic table done");
      u_spm_cfg_master.wr(8'h04, 32'(ST_DIS), r);
      u_spm_cfg_master.rd(8'h44, d, r);
      chk(32'(d[9:8]), 32'h1);
      u_spm_cfg_master.wait_cc(4'h1, d);
      chk(32'({d[9], port_mode_eff[3]}), {29'h0, 1'b1, PM_DIS});
      u_spm_cfg_master.wr(8'h04, 32'(ST_RSVD), r);
      u_spm_cfg_master.rd(8'h04, d, r);
      chk(32'(d[1:0]), 32'(ST_DIS));
      u_spm_cfg_master.wr(8'h44, 32'h300, r);
      u_spm_cfg_master.rd(8'h44, d, r);
      chk(d & 32'h300, 32'h0);
      t0 = $time;
      u_spm_cfg_master.wr(8'h08, 32'(ST_FR), r);
      u_spm_cfg_master.wait_cc(4'h2, d);
      chk(32'(($time - t0) >= 20 * 25), 32'h1);
      chk(32'({d[9], port_fund_rst[5]}), 32'h3);
      u_spm_cfg_master.wr(8'h48, 32'h300, r);
      u_spm_cfg_master.wr(8'hD0, 32'h4, r);
      pin_n <= 16'hFFFB;
      u_spm_cfg_master.wr(8'h08, 32'(ST_ACT), r);
      repeat (40) @(posedge clk_sys);
      u_spm_cfg_master.rd(8'h48, d, r);
      chk(32'(d[9]), 32'h0);
      pin_n <= 16'hFFFF;
      u_spm_cfg_master.wait_cc(4'h2, d);
      #1 chk(32'({d[9], port_fund_rst[5]}), 32'h2);
      $display("state change tests done");
      arst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      chk(32'(port_mode_eff[3]), 32'(PM_RST_VAL));
      arst_n <= 1'b1;
      @(posedge clk_sys);
      u_spm_cfg_master.rd(8'h04, d, r);
      chk(d, 32'(ST_RST_VAL));
      u_spm_cfg_master.rd(8'h48, d, r);
      chk(d, 32'h0);
      $display("mid-run reset test done");
      for (int i = 0; i < 4; i++) u_spm_cfg_master.wr(8'hC0 + 8'(4 * i), 32'h0, r);
      t0 = $time;
      u_spm_cfg_master.wr(8'h1C, 32'(ST_DIS), r);
      u_spm_cfg_master.wait_cc(4'h7, d);
      chk(32'(($time - t0) < 8 * 25), 32'h1);
      u_spm_cfg_master.wr(8'hC4, 32'(SE_CYC_DEF), r);
      u_spm_cfg_master.wr(8'hC8, 32'(MC_CYC_DEF), r);
      u_spm_cfg_master.wr(8'hCC, 32'(USBR_DEF), r);
      u_spm_cfg_master.rd(8'hC8, d, r);
      chk(d, 32'(MC_CYC_DEF));
      $display("loader sequence test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
